// file: logic/vbis_top.sv
// Interrupt status, mask and teletext FIFO control logic of the video decoder.
// Summary of operation
// - Teletext data bit sets when buffer holds a transaction on the interrupt line.
// - Teletext threshold bit sets once buffered transactions reach the threshold count.
// - Bus error bit sets when the host interface reports an illegal access.
// - Cycle complete bit reads zero during a host cycle, one afterwards.
// - Lock change bit sets on every rising or falling horizontal lock edge.
// - Top status bit follows the present horizontal lock state live.
// - Latched status bits stay set until the host writes one to them; a FIFO reset also clears the two teletext bits.
// - Interrupt line, checked at line start, gates teletext data and caption bits; zero disables.
// - Threshold count is programmable and resets to five transactions.
// - Enable mask gates only the interrupt pin, never the status bits.
`timescale 1ns/1ps

module vbis_top (
  input  wire logic                    mclk_i,
  input  wire logic                    rstn_i,
  input  wire vbis_pkg::vbis_host_req_s host_req_i,
  input  wire logic                    host_busy_i,
  input  wire logic                    host_illegal_i,
  input  wire vbis_pkg::vbis_ttx_in_s  ttx_in_i,
  input  wire logic [5:0]              ttx_txn_len_i,
  input  wire logic                    line_start_i,
  input  wire logic [9:0]              line_number_i,
  input  wire logic                    cc_odd_avail_i,
  input  wire logic                    cc_even_avail_i,
  input  wire logic                    horizontal_lock_i,
  output logic [7:0]                   host_rdata_o,
  output logic                         irq_o,
  output logic                         ttx_full_o
);
  import vbis_pkg::*;

  typedef struct packed {
    logic [6:0]          stat;
    logic [7:0]          int_en;
    logic [3:0]          thresh;
    logic [4:0]          int_line;
    logic                data_req;
    logic                readout_en;
    logic [VBIS_FIFO_AW:0] wptr;
    logic [VBIS_FIFO_AW:0] rptr;
    logic [3:0]          txn_cnt;
    logic [5:0]          rd_bytes;
    logic [7:0]          last_byte;
    logic [7:0]          rdata;
    logic                irq;
    logic                full;
    logic                lock_q;
    logic                busy_q;
  } vbis_state_s;

  vbis_state_s st_ff;
  vbis_state_s nxt_st;
  logic [7:0]  fifo_mem [VBIS_FIFO_DEPTH];
  logic [1:0]  rst_sync_ff;
  logic        rstn_int;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  // Reset asserts at once but leaves on the clock, so no flop sees a ragged release.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rstn_int = rst_sync_ff[1];

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  // True when the host request is a write to the given offset.
  function automatic logic is_wr(input vbis_host_req_s r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  logic                  empty;
  logic                  push;
  logic                  pop;
  logic                  txn_in;
  logic                  txn_out;
  logic                  line_hit;
  logic                  fifo_rst;
  logic [7:0]            stat_rd;
  logic [7:0]            buf_rd;
  logic [7:0]            clr_mask;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    empty    = (st_ff.wptr == st_ff.rptr);
    fifo_rst = is_wr(host_req_i, VBIS_OFS_FIFO_CTRL) && host_req_i.wdata[VBIS_FC_FIFO_RESET];
    push     = ttx_in_i.valid && !st_ff.full;
    pop      = host_req_i.rd && (host_req_i.addr == VBIS_OFS_TTX_DATA) && st_ff.readout_en && !empty;
    txn_in   = push && ttx_in_i.last && (st_ff.txn_cnt != 4'hf);
    txn_out  = pop && (st_ff.rd_bytes + 6'h01 >= ttx_txn_len_i) && (st_ff.txn_cnt != 4'h0);
    // Lines number from one, so a zero line setting never matches.
    line_hit = line_start_i && (st_ff.int_line != 5'h00)
               && (line_number_i == {5'h00, st_ff.int_line});
    clr_mask = is_wr(host_req_i, VBIS_OFS_INT_STAT) ? host_req_i.wdata : 8'h00;

    // Live bits are built at read time rather than stored as sticky flags.
    stat_rd = {st_ff.lock_q, st_ff.stat[VBIS_ST_LOCK_CHG], !st_ff.busy_q, st_ff.stat[4:0]};
    stat_rd[VBIS_ST_CYC_DONE] = !st_ff.busy_q;
    stat_rd[VBIS_ST_LOCK_NOW] = st_ff.lock_q;
    buf_rd  = {1'b0, 1'b0, 1'b0, st_ff.txn_cnt, (st_ff.txn_cnt != 4'h0)};
    buf_rd[1] = st_ff.full;
    buf_rd[5:2] = st_ff.txn_cnt;

    // Sticky status: clear first, then let any new event win the same cycle; a FIFO reset still beats the two teletext events.
    nxt_st.stat = st_ff.stat & ~clr_mask[6:0];
    if (line_hit && (st_ff.txn_cnt != 4'h0 || !st_ff.data_req)) begin
      nxt_st.stat[VBIS_ST_TTX_DATA] = 1'b1;
    end
    if (st_ff.txn_cnt >= st_ff.thresh && st_ff.txn_cnt != 4'h0) begin
      nxt_st.stat[VBIS_ST_TTX_THRESH] = 1'b1;
    end
    if (line_hit && cc_even_avail_i) begin
      nxt_st.stat[VBIS_ST_CC_EVEN] = 1'b1;
    end
    if (line_hit && cc_odd_avail_i) begin
      nxt_st.stat[VBIS_ST_CC_ODD] = 1'b1;
    end
    if (host_illegal_i) begin
      nxt_st.stat[VBIS_ST_BUS_ERR] = 1'b1;
    end
    nxt_st.stat[VBIS_ST_CYC_DONE] = 1'b0;
    if (horizontal_lock_i != st_ff.lock_q) begin
      nxt_st.stat[VBIS_ST_LOCK_CHG] = 1'b1;
    end
    nxt_st.lock_q = horizontal_lock_i;
    nxt_st.busy_q = host_busy_i;

    // Configuration writes.
    if (is_wr(host_req_i, VBIS_OFS_THRESH)) begin
      nxt_st.thresh = host_req_i.wdata[3:0];
    end
    if (is_wr(host_req_i, VBIS_OFS_INT_LINE)) begin
      nxt_st.int_line = host_req_i.wdata[4:0];
      nxt_st.data_req = host_req_i.wdata[VBIS_IL_DATA_REQ];
    end
    if (is_wr(host_req_i, VBIS_OFS_INT_EN)) begin
      nxt_st.int_en = {1'b0, host_req_i.wdata[6:0]};
    end
    if (is_wr(host_req_i, VBIS_OFS_FIFO_CTRL)) begin
      nxt_st.readout_en = host_req_i.wdata[VBIS_FC_READOUT_EN];
    end

    // FIFO pointers and the complete-transaction count.
    if (push) begin
      nxt_st.wptr = st_ff.wptr + 9'h001;
    end
    if (pop) begin
      nxt_st.rptr      = st_ff.rptr + 9'h001;
      nxt_st.last_byte = fifo_mem[st_ff.rptr[VBIS_FIFO_AW-1:0]];
      nxt_st.rd_bytes  = txn_out ? 6'h00 : st_ff.rd_bytes + 6'h01;
    end
    nxt_st.txn_cnt = st_ff.txn_cnt + {3'h0, txn_in} - {3'h0, txn_out};
    if (fifo_rst) begin
      nxt_st.wptr     = '0;
      nxt_st.rptr     = '0;
      nxt_st.txn_cnt  = 4'h0;
      nxt_st.rd_bytes = 6'h00;
      nxt_st.stat[VBIS_ST_TTX_DATA]   = 1'b0;
      nxt_st.stat[VBIS_ST_TTX_THRESH] = 1'b0;
    end
    nxt_st.full = (nxt_st.wptr[VBIS_FIFO_AW] != nxt_st.rptr[VBIS_FIFO_AW])
                  && (nxt_st.wptr[VBIS_FIFO_AW-1:0] == nxt_st.rptr[VBIS_FIFO_AW-1:0]);

    // Mask reaches the pin only; the status bits above ignore it.
    nxt_st.irq = |({stat_rd[7], stat_rd[6:0]} & st_ff.int_en);

    // Read data is registered, one cycle after the read strobe.
    nxt_st.rdata = 8'h00;
    if (host_req_i.rd) begin
      if (host_req_i.addr == VBIS_OFS_TTX_DATA) begin
        nxt_st.rdata = pop ? fifo_mem[st_ff.rptr[VBIS_FIFO_AW-1:0]] : st_ff.last_byte;
      end else if (host_req_i.addr == VBIS_OFS_BUF_STAT) begin
        nxt_st.rdata = buf_rd;
      end else if (host_req_i.addr == VBIS_OFS_THRESH) begin
        nxt_st.rdata = {4'h0, st_ff.thresh};
      end else if (host_req_i.addr == VBIS_OFS_INT_LINE) begin
        nxt_st.rdata = {2'h0, st_ff.data_req, st_ff.int_line};
      end else if (host_req_i.addr == VBIS_OFS_FIFO_CTRL) begin
        nxt_st.rdata = {4'h0, (st_ff.rd_bytes != 6'h00), 1'b0, st_ff.readout_en, 1'b0};
      end else if (host_req_i.addr == VBIS_OFS_INT_STAT) begin
        nxt_st.rdata = stat_rd;
      end else if (host_req_i.addr == VBIS_OFS_INT_EN) begin
        nxt_st.rdata = st_ff.int_en;
      end else if (host_req_i.addr == VBIS_OFS_INT_CFG) begin
        nxt_st.rdata = {6'h00, st_ff.irq, 1'b0};
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register and FIFO storage
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_int) begin
    if (!rstn_int) begin
      st_ff          <= '0;
      st_ff.int_en   <= VBIS_INT_EN_RST;
      st_ff.thresh   <= VBIS_THRESH_RST;
      st_ff.int_line <= VBIS_INT_LINE_RST;
      st_ff.data_req <= VBIS_DATA_REQ_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage has no reset; the pointers alone decide what is valid.
  always_ff @(posedge mclk_i) begin
    if (push) begin
      fifo_mem[st_ff.wptr[VBIS_FIFO_AW-1:0]] <= ttx_in_i.data;
    end
  end

  assign host_rdata_o = st_ff.rdata;
  assign irq_o        = st_ff.irq;
  assign ttx_full_o   = st_ff.full;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  ttx_data_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    $rose(st_ff.stat[VBIS_ST_TTX_DATA]) |-> $past(line_hit))
    else $error("teletext data bit set off the interrupt line");
  thresh_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    (st_ff.txn_cnt >= st_ff.thresh && st_ff.txn_cnt != 4'h0 && !fifo_rst) |=> st_ff.stat[VBIS_ST_TTX_THRESH])
    else $error("threshold bit missed");
  bus_err_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    host_illegal_i |=> st_ff.stat[VBIS_ST_BUS_ERR])
    else $error("bus error not latched");
  // A cycle open one clock before a status read must show as not complete.
  cycle_done_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    host_busy_i ##1 (host_req_i.rd && host_req_i.addr == VBIS_OFS_INT_STAT) |=>
      !host_rdata_o[VBIS_ST_CYC_DONE])
    else $error("cycle complete read as one during a cycle");
  lock_edge_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    $changed(horizontal_lock_i) |=> st_ff.stat[VBIS_ST_LOCK_CHG])
    else $error("lock change not flagged");
  lock_live_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    host_req_i.rd && host_req_i.addr == VBIS_OFS_INT_STAT |=> host_rdata_o[7] == $past(st_ff.lock_q))
    else $error("lock state bit stale");
  fifo_reset_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    fifo_rst |=> (st_ff.txn_cnt == 4'h0 && st_ff.rptr == '0 && st_ff.wptr == '0
                  && !st_ff.stat[VBIS_ST_TTX_DATA] && !st_ff.stat[VBIS_ST_TTX_THRESH]))
    else $error("fifo reset incomplete");
  sticky_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    st_ff.stat[VBIS_ST_BUS_ERR] && !clr_mask[VBIS_ST_BUS_ERR] |=> st_ff.stat[VBIS_ST_BUS_ERR])
    else $error("status bit lost without a clear");
  line_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    (st_ff.int_line == 5'h00) && !st_ff.stat[VBIS_ST_CC_ODD] |=> !st_ff.stat[VBIS_ST_CC_ODD])
    else $error("line zero did not disable");
  mask_pin_a: assert property (@(posedge mclk_i) disable iff (!rstn_int)
    (st_ff.int_en == 8'h00) ##1 (st_ff.int_en == 8'h00) |-> !irq_o)
    else $error("masked condition reached the pin");

endmodule : vbis_top

// file: logic/vbis_pkg.sv
// Package of constants and carrier types for the caption and teletext interrupt status block.
package vbis_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets on the host register port
  // ---------------------------------------------------------------------------
  localparam logic [7:0] VBIS_OFS_TTX_DATA  = 8'hb0;
  localparam logic [7:0] VBIS_OFS_BUF_STAT  = 8'hb3;
  localparam logic [7:0] VBIS_OFS_THRESH    = 8'hb4;
  localparam logic [7:0] VBIS_OFS_INT_LINE  = 8'hb5;
  localparam logic [7:0] VBIS_OFS_FIFO_CTRL = 8'hb6;
  localparam logic [7:0] VBIS_OFS_INT_STAT  = 8'hc0;
  localparam logic [7:0] VBIS_OFS_INT_EN    = 8'hc1;
  localparam logic [7:0] VBIS_OFS_INT_CFG   = 8'hc2;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int VBIS_ST_TTX_DATA   = 0;
  localparam int VBIS_ST_TTX_THRESH = 1;
  localparam int VBIS_ST_CC_EVEN    = 2;
  localparam int VBIS_ST_CC_ODD     = 3;
  localparam int VBIS_ST_BUS_ERR    = 4;
  localparam int VBIS_ST_CYC_DONE   = 5;
  localparam int VBIS_ST_LOCK_CHG   = 6;
  localparam int VBIS_ST_LOCK_NOW   = 7;
  localparam int VBIS_FC_FIFO_RESET = 0;
  localparam int VBIS_FC_READOUT_EN = 1;
  localparam int VBIS_FC_RD_PROG    = 3;
  localparam int VBIS_IL_DATA_REQ   = 5;
  localparam int VBIS_CFG_IRQ_STATE = 1;

  // ---------------------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------------------
  localparam logic [4:0] VBIS_INT_LINE_RST = 5'h18;
  localparam logic [3:0] VBIS_THRESH_RST   = 4'h5;
  localparam logic       VBIS_DATA_REQ_RST = 1'b1;
  localparam logic [7:0] VBIS_INT_EN_RST   = 8'h00;
  localparam int         VBIS_FIFO_AW      = 8;
  localparam int         VBIS_FIFO_DEPTH   = 256;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } vbis_host_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } vbis_ttx_in_s;

endpackage : vbis_pkg

// file: tb/vbis_host_model.sv
// Host processor model that drives the register port of the status block.
`timescale 1ns/1ps
module vbis_host_model
  import vbis_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic [7:0] host_rdata_i,
  output vbis_host_req_s  host_req_o,
  output logic            host_busy_o
);
  // ---------------------------------------------------------------------------
  // Register port accesses
  // ---------------------------------------------------------------------------
  initial begin
    host_req_o = '0;
    host_busy_o = 1'b0;
  end

  // A request launches after a falling edge and holds across one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    host_req_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge mclk_i);
    host_req_o.wr = 1'b0;
    host_req_o.wdata = ~d; // Released data is scrambled so stale bytes are never trusted.
  endtask

  // Read data is taken one cycle after the request edge, as the port answers.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    host_req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge mclk_i);
    d = host_rdata_i;
    host_req_o.rd = 1'b0;
  endtask

  // Acknowledging a status condition writes a one to its bit only.
  task automatic w1c(input logic [7:0] m);
    wr(VBIS_OFS_INT_STAT, m);
  endtask

  // A slow host keeps its bus cycle open for as long as it likes.
  task automatic busy(input logic b);
    @(negedge mclk_i);
    host_busy_o = b;
  endtask
endmodule // vbis_host_model

// file: tb/vbis_testbench.sv
// Self-checking testbench of the interrupt status and teletext control block.
`timescale 1ns/1ps
module testbench;
  import vbis_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} vbis_row_s;
  logic           mclk_i, rstn_i, illegal, lstart, cc_odd, cc_even, lock;
  vbis_host_req_s req;
  logic           busy, irq, full;
  vbis_ttx_in_s   ttx;
  logic [5:0]     txn_len;
  logic [9:0]     line_no;
  logic [7:0]     rdata;
  int             mismatches, num_checks, cycles;
  vbis_row_s      rows [5];

  vbis_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .host_req_i(req), .host_busy_i(busy),
    .host_illegal_i(illegal), .ttx_in_i(ttx), .ttx_txn_len_i(txn_len), .line_start_i(lstart),
    .line_number_i(line_no), .cc_odd_avail_i(cc_odd), .cc_even_avail_i(cc_even),
    .horizontal_lock_i(lock), .host_rdata_o(rdata), .irq_o(irq), .ttx_full_o(full));
  vbis_host_model host (.mclk_i(mclk_i), .host_rdata_i(rdata), .host_req_o(req), .host_busy_o(busy));

  // ---------------------------------------------------------------------------
  // Clock, watchdog and helpers
  // ---------------------------------------------------------------------------
  initial mclk_i = 1'b0;
  always #10 mclk_i = ~mclk_i;

  // The whole run needs under fifteen hundred cycles; a hang ends it here.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    check($sformatf("reg %h", a), d & m, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // A line start carries the line number for one cycle, then settles.
  task automatic pulse(input logic [9:0] n);
    @(negedge mclk_i);
    line_no = n;
    lstart = 1'b1;
    @(negedge mclk_i);
    lstart = 1'b0;
    idle(2);
  endtask

  task automatic push(input logic [7:0] b, input logic lst);
    @(negedge mclk_i);
    ttx = '{valid: 1'b1, data: b, last: lst};
    @(negedge mclk_i);
    ttx.valid = 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rstn_i, illegal, lstart, cc_odd, cc_even, lock} = '0;
    ttx = '0;
    txn_len = 6'h02;
    line_no = 10'h000;
    rows = '{'{8'hb4, 8'h03, 8'h03}, '{8'hb5, 8'h2a, 8'h2a}, '{8'hc1, 8'hff, 8'h7f},
             '{8'hb6, 8'h03, 8'h02}, '{8'h55, 8'hff, 8'h00}};
    idle(16);
    rstn_i = 1'b1;
    idle(4);
    // Plain register writes read back through the mask of each field.
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, 8'hff, rows[i].e);
    end
    // A second reset in mid-run must bring back the defaults.
    rstn_i = 1'b0;
    idle(2);
    rstn_i = 1'b1;
    idle(4);
    rd_chk(VBIS_OFS_THRESH, 8'hff, 8'h05);
    rd_chk(VBIS_OFS_INT_LINE, 8'hff, 8'h38);
    // Lock edges latch, the live bit follows, and only the mask reaches the pin.
    lock = 1'b1;
    idle(4);
    rd_chk(VBIS_OFS_INT_STAT, 8'hc0, 8'hc0);
    check("irq masked", {7'h00, irq}, 8'h00);
    host.w1c(8'h40);
    rd_chk(VBIS_OFS_INT_STAT, 8'hc0, 8'h80);
    host.wr(VBIS_OFS_INT_EN, 8'h40);
    lock = 1'b0;
    idle(4);
    check("irq enabled", {7'h00, irq}, 8'h01);
    rd_chk(VBIS_OFS_INT_STAT, 8'hc0, 8'h40);
    host.w1c(8'h40);
    idle(3);
    check("irq cleared", {7'h00, irq}, 8'h00);
    // An illegal access latches until acknowledged.
    illegal = 1'b1;
    idle(1);
    illegal = 1'b0;
    idle(2);
    rd_chk(VBIS_OFS_INT_STAT, 8'h10, 8'h10);
    host.w1c(8'h10);
    rd_chk(VBIS_OFS_INT_STAT, 8'h10, 8'h00);
    // Cycle complete drops while the host keeps its cycle open.
    host.busy(1'b1);
    idle(3);
    rd_chk(VBIS_OFS_INT_STAT, 8'h20, 8'h00);
    host.busy(1'b0);
    idle(3);
    rd_chk(VBIS_OFS_INT_STAT, 8'h20, 8'h20);
    // Teletext data needs a buffered transaction and the matching line.
    host.wr(VBIS_OFS_THRESH, 8'h01);
    host.wr(VBIS_OFS_INT_LINE, 8'h25);
    pulse(10'd5);
    rd_chk(VBIS_OFS_INT_STAT, 8'h03, 8'h00);
    push(8'h5a, 1'b0);
    push(8'ha5, 1'b1);
    idle(2);
    rd_chk(VBIS_OFS_INT_STAT, 8'h02, 8'h02);
    rd_chk(VBIS_OFS_BUF_STAT, 8'h3f, 8'h05);
    pulse(10'd6);
    rd_chk(VBIS_OFS_INT_STAT, 8'h01, 8'h00);
    cc_odd = 1'b1;
    cc_even = 1'b1;
    pulse(10'd5);
    rd_chk(VBIS_OFS_INT_STAT, 8'h0f, 8'h0f);
    host.w1c(8'h0f);
    host.wr(VBIS_OFS_INT_LINE, 8'h20);
    pulse(10'd0);
    rd_chk(VBIS_OFS_INT_STAT, 8'h0d, 8'h00);
    // A FIFO reset empties the buffer and its availability flags.
    host.wr(VBIS_OFS_FIFO_CTRL, 8'h01);
    idle(2);
    rd_chk(VBIS_OFS_BUF_STAT, 8'h3f, 8'h00);
    rd_chk(VBIS_OFS_INT_STAT, 8'h03, 8'h00);
    // Readout hands out one byte per read and counts a transaction off after its last byte.
    txn_len = 6'h03;
    host.wr(VBIS_OFS_FIFO_CTRL, 8'h02);
    push(8'h11, 1'b0);
    push(8'h22, 1'b0);
    push(8'h33, 1'b1);
    rd_chk(VBIS_OFS_TTX_DATA, 8'hff, 8'h11);
    rd_chk(VBIS_OFS_FIFO_CTRL, 8'h08, 8'h08);
    rd_chk(VBIS_OFS_TTX_DATA, 8'hff, 8'h22);
    rd_chk(VBIS_OFS_TTX_DATA, 8'hff, 8'h33);
    rd_chk(VBIS_OFS_BUF_STAT, 8'h3f, 8'h00);
    rd_chk(VBIS_OFS_FIFO_CTRL, 8'h08, 8'h00);
    rd_chk(VBIS_OFS_TTX_DATA, 8'hff, 8'h33);
    // With data not required, the matching line alone sets the teletext data bit.
    host.wr(VBIS_OFS_INT_LINE, 8'h07);
    pulse(10'd7);
    rd_chk(VBIS_OFS_INT_STAT, 8'h01, 8'h01);
    host.wr(VBIS_OFS_INT_EN, 8'h01);
    idle(2);
    check("irq data", {7'h00, irq}, 8'h01);
    rd_chk(VBIS_OFS_INT_CFG, 8'h02, 8'h02);
    // Filling all storage raises the full flag; a FIFO reset drops it again.
    @(negedge mclk_i);
    ttx = '{valid: 1'b1, data: 8'h77, last: 1'b0};
    repeat (VBIS_FIFO_DEPTH) @(negedge mclk_i);
    ttx.valid = 1'b0;
    check("full", {7'h00, full}, 8'h01);
    rd_chk(VBIS_OFS_BUF_STAT, 8'h3f, 8'h02);
    host.wr(VBIS_OFS_FIFO_CTRL, 8'h01);
    idle(2);
    check("full cleared", {7'h00, full}, 8'h00);
    rd_chk(VBIS_OFS_BUF_STAT, 8'h3f, 8'h00);
    print_verdict();
  end
endmodule // testbench
